// ### mcd_pkg.sv
package mcd_pkg;
   localparam int INSTR_W = 48;
   localparam int ADDR_W = 24;
   localparam int CF_W = 23;
   localparam int REG_SEL_W = 4;
   // opcode fields of the upper word
   localparam logic [8:0] OP_MISC_HI = 9'h000;          // bits 47:39 minus bit 39
   localparam int MISC_HI_MSB = 47;
   localparam int MISC_HI_LSB = 40;
   localparam logic [7:0] OP_MISC = 8'h00;
   localparam int WAIT_BIT = 39;
   localparam logic [7:0] OP_FRAME_HI = 8'h18;           // bits 47:40 of jump form
   localparam logic [7:0] OP_RESTORE_HI = 8'h19;         // bits 47:40 of restore form
   localparam int SUB_MSB = 39;
   localparam int SUB_LSB = 36;
   localparam logic [3:0] SUB_DIRECT = 4'h0;
   localparam logic [3:0] SUB_REL = 4'h4;
   localparam logic [3:0] SUB_SAVE_TAIL = 4'h4;          // bits 35:32 of jump form
   localparam int TAIL_MSB = 35;
   localparam int TAIL_LSB = 32;
   // compute field layout
   localparam int CU_MSB = 21;
   localparam int CU_LSB = 20;
   localparam int CFOP_MSB = 19;
   localparam int CFOP_LSB = 12;
   localparam int RN_MSB = 11;
   localparam int RN_LSB = 8;
   localparam int RX_MSB = 7;
   localparam int RX_LSB = 4;
   localparam int RY_MSB = 3;
   localparam int RY_LSB = 0;
   localparam int CF_MULTI_BIT = 22;
   localparam logic [1:0] CU_ALU = 2'h0;
   localparam logic [1:0] CU_MUL = 2'h1;
   localparam logic [1:0] CU_SHF = 2'h2;
   localparam logic [1:0] CU_ACC = 2'h3;
   // shifter ops whose opcode top bit is set also read the result register
   localparam int SHF_THIRD_BIT = 19;
   localparam int RESTORE_OFS0 = 0;
   localparam int RESTORE_OFS1 = 1;
   typedef enum logic [1:0] {
      MCD_RUN = 2'b00,
      MCD_WAIT = 2'b01
   } mcd_state_t;
   typedef enum logic [2:0] {
      MCD_UNIT_NONE = 3'b000,
      MCD_UNIT_ALU = 3'b001,
      MCD_UNIT_MUL = 3'b010,
      MCD_UNIT_SHF = 3'b011,
      MCD_UNIT_MULTI = 3'b100,
      MCD_UNIT_ACC = 3'b101
   } mcd_unit_t;
endpackage

// ### mcd_compute_dec.sv
`timescale 1ns/1ps
module mcd_compute_dec #(
   parameter int CF_W = 23
) (
   input wire logic [CF_W-1:0] cf_i,      // compute field
   output mcd_pkg::mcd_unit_t unit_o,     // selected unit
   output logic [7:0] op_o,               // unit opcode
   output logic [3:0] rn_o,               // result select
   output logic [3:0] rx_o,               // x operand select
   output logic [3:0] ry_o,               // y operand select
   output logic rn_is_src_o               // result also read
);
   initial begin
      if (CF_W != 23) $error("compute field must be 23 bits");
   end
   always_comb begin
      op_o = cf_i[mcd_pkg::CFOP_MSB:mcd_pkg::CFOP_LSB];
      rn_o = cf_i[mcd_pkg::RN_MSB:mcd_pkg::RN_LSB];
      rx_o = cf_i[mcd_pkg::RX_MSB:mcd_pkg::RX_LSB];
      ry_o = cf_i[mcd_pkg::RY_MSB:mcd_pkg::RY_LSB];
      rn_is_src_o = 1'b0;
      if (cf_i[mcd_pkg::CF_MULTI_BIT]) begin
         unit_o = mcd_pkg::MCD_UNIT_MULTI;
      end else begin
         case (cf_i[mcd_pkg::CU_MSB:mcd_pkg::CU_LSB])
            mcd_pkg::CU_ALU: unit_o = mcd_pkg::MCD_UNIT_ALU;
            mcd_pkg::CU_MUL: unit_o = mcd_pkg::MCD_UNIT_MUL;
            mcd_pkg::CU_SHF: begin
               unit_o = mcd_pkg::MCD_UNIT_SHF;
               rn_is_src_o = cf_i[mcd_pkg::SHF_THIRD_BIT];
            end
            default: unit_o = mcd_pkg::MCD_UNIT_ACC;
         endcase
      end
   end
endmodule

// ### mcd_target_calc.sv
`timescale 1ns/1ps
module mcd_target_calc #(
   parameter int ADDR_W = 24
) (
   input wire logic [ADDR_W-1:0] pc_i,    // current program counter
   input wire logic [ADDR_W-1:0] field_i, // low address field
   input wire logic rel_i,                // field is pc_offset_field
   output logic [ADDR_W-1:0] target_o     // branch target
);
   initial begin
      if (ADDR_W < 2) $error("address width too small");
   end
   // two's-complement add wraps modulo the address space
   always_comb begin
      if (rel_i) begin
         target_o = pc_i + field_i;
      end else begin
         target_o = field_i;
      end
   end
endmodule

// ### mcd_misc_decode.sv
`timescale 1ns/1ps
// What this block does
// - no-operation changes nothing except advancing the fetch address
// - low-power wait acts as no-operation then enters reduced power
// - only a raised interrupt ends the reduced power state
// - after service return, execution resumes after the wait instruction
// - frame-save jump: delayed branch, save frame pointer, frame pointer from stack
// - dual mode saves to y register too; restore also loads offset one
// - frame-restore: stack pointer from frame pointer, load frame pointer offset zero
// - direct form carries a 24-bit absolute target address
// - relative form adds signed 24-bit offset to program counter
// - nibble 0100 selects relative form, 0000 the direct form
// - compute field is a 23-bit sub-instruction in the word
// - unit select 00 ALU, 01 multiplier, 10 shifter
// - operands from x and y selects, result to result select
// - some shifter ops also read the result register as source
// - multifunction encodings run units in parallel
// - dedicated encoding gives accumulator_transfer access
module mcd_misc_decode #(
   parameter int ADDR_W = 24,
   parameter int CF_W = 23
) (
   input wire logic clock_i,                   // core clock
   input wire logic arst_n_i,                  // async reset, active low
   input wire logic instr_valid_i,             // instruction word present
   input wire logic [47:0] instr_i,            // instruction word
   input wire logic [ADDR_W-1:0] pc_i,         // address of this instruction
   input wire logic dual_element_mode_i,       // dual element mode active
   input wire logic irq_i,                     // interrupt raised
   input wire logic [31:0] frame_pointer_i,    // frame pointer value
   input wire logic [31:0] stack_pointer_i,    // stack pointer value
   input wire logic [31:0] mem_rdata_i,        // data_memory read data
   input wire logic mem_rvalid_i,              // data_memory read returned
   output logic instr_ready_o,                 // decoder takes a word
   output logic fetch_advance_o,               // step fetch address
   output logic low_power_o,                   // reduced power state
   output logic [ADDR_W-1:0] resume_addr_o,    // address after wait
   output logic branch_o,                      // delayed branch request
   output logic [ADDR_W-1:0] branch_target_o,  // branch target
   output logic pex_save_we_o,                 // write pex_save_register
   output logic pey_save_we_o,                 // write pey_save_register
   output logic [31:0] save_data_o,            // save register data
   output logic sp_we_o,                       // write stack pointer
   output logic [31:0] sp_data_o,              // stack pointer data
   output logic fp_we_o,                       // write frame pointer
   output logic [31:0] fp_data_o,              // frame pointer data
   output logic mem_rd_o,                      // data_memory read strobe
   output logic [31:0] mem_addr_o,             // data_memory address
   output logic cmp_valid_o,                   // compute issued
   output mcd_pkg::mcd_unit_t cmp_unit_o,      // compute unit
   output logic [7:0] cmp_op_o,                // compute opcode
   output logic [3:0] cmp_rn_o,                // result register
   output logic [3:0] cmp_rx_o,                // x operand register
   output logic [3:0] cmp_ry_o,                // y operand register
   output logic cmp_rn_src_o                   // result register also read
);
   initial begin
      if (ADDR_W != mcd_pkg::ADDR_W) $error("address field is 24 bits");
      if (CF_W != mcd_pkg::CF_W) $error("compute field is 23 bits");
   end

   mcd_pkg::mcd_state_t state_ff, nxt_state;
   logic [ADDR_W-1:0] resume_ff, nxt_resume;
   logic branch_ff, nxt_branch;
   logic [ADDR_W-1:0] target_ff, nxt_target;
   logic pex_we_ff, nxt_pex_we;
   logic pey_we_ff, nxt_pey_we;
   logic [31:0] save_ff, nxt_save;
   logic sp_we_ff, nxt_sp_we;
   logic [31:0] sp_ff, nxt_sp;
   logic fp_we_ff, nxt_fp_we;
   logic [31:0] fp_ff, nxt_fp;
   logic mem_rd_ff, nxt_mem_rd;
   logic [31:0] mem_addr_ff, nxt_mem_addr;
   logic [1:0] loads_ff, nxt_loads;
   logic adv_ff, nxt_adv;
   logic cv_ff, nxt_cv;
   mcd_pkg::mcd_unit_t cu_ff, nxt_cu;
   logic [7:0] cop_ff, nxt_cop;
   logic [3:0] crn_ff, nxt_crn;
   logic [3:0] crx_ff, nxt_crx;
   logic [3:0] cry_ff, nxt_cry;
   logic crs_ff, nxt_crs;

   logic is_misc, is_nop, is_wait, is_save, is_restore, rel_form;
   logic [ADDR_W-1:0] tgt;
   mcd_pkg::mcd_unit_t dec_unit;
   logic [7:0] dec_op;
   logic [3:0] dec_rn, dec_rx, dec_ry;
   logic dec_rs;
   logic take;

   mcd_target_calc #(.ADDR_W(ADDR_W)) u_tgt (
      .pc_i(pc_i),
      .field_i(instr_i[ADDR_W-1:0]),
      .rel_i(rel_form),
      .target_o(tgt)
   );

   mcd_compute_dec #(.CF_W(CF_W)) u_cdec (
      .cf_i(instr_i[CF_W-1:0]),
      .unit_o(dec_unit),
      .op_o(dec_op),
      .rn_o(dec_rn),
      .rx_o(dec_rx),
      .ry_o(dec_ry),
      .rn_is_src_o(dec_rs)
   );

   // restore waits for its loads; wait holds off new words
   assign instr_ready_o = (state_ff == mcd_pkg::MCD_RUN) && (loads_ff == 2'h0);
   assign take = instr_valid_i && instr_ready_o;

   always_comb begin
      is_misc = instr_i[mcd_pkg::MISC_HI_MSB:mcd_pkg::MISC_HI_LSB] == mcd_pkg::OP_MISC;
      is_nop = is_misc && !instr_i[mcd_pkg::WAIT_BIT];
      is_wait = is_misc && instr_i[mcd_pkg::WAIT_BIT];
      is_save = (instr_i[mcd_pkg::MISC_HI_MSB:mcd_pkg::MISC_HI_LSB] == mcd_pkg::OP_FRAME_HI)
         && (instr_i[mcd_pkg::TAIL_MSB:mcd_pkg::TAIL_LSB] == mcd_pkg::SUB_SAVE_TAIL)
         && ((instr_i[mcd_pkg::SUB_MSB:mcd_pkg::SUB_LSB] == mcd_pkg::SUB_DIRECT)
         || (instr_i[mcd_pkg::SUB_MSB:mcd_pkg::SUB_LSB] == mcd_pkg::SUB_REL));
      rel_form = instr_i[mcd_pkg::SUB_MSB:mcd_pkg::SUB_LSB] == mcd_pkg::SUB_REL;
      is_restore =
         instr_i[mcd_pkg::MISC_HI_MSB:mcd_pkg::MISC_HI_LSB] == mcd_pkg::OP_RESTORE_HI;
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_resume = resume_ff;
      nxt_branch = 1'b0;
      nxt_target = target_ff;
      nxt_pex_we = 1'b0;
      nxt_pey_we = 1'b0;
      nxt_save = save_ff;
      nxt_sp_we = 1'b0;
      nxt_sp = sp_ff;
      nxt_fp_we = 1'b0;
      nxt_fp = fp_ff;
      nxt_mem_rd = 1'b0;
      nxt_mem_addr = mem_addr_ff;
      nxt_loads = loads_ff;
      nxt_adv = 1'b0;
      nxt_cv = 1'b0;
      nxt_cu = cu_ff;
      nxt_cop = cop_ff;
      nxt_crn = crn_ff;
      nxt_crx = crx_ff;
      nxt_cry = cry_ff;
      nxt_crs = crs_ff;
      case (state_ff)
         mcd_pkg::MCD_RUN: begin
            if (take) begin
               nxt_adv = 1'b1;
               if (is_wait) begin
                  nxt_state = mcd_pkg::MCD_WAIT;
                  nxt_resume = pc_i + {{(ADDR_W-1){1'b0}}, 1'b1};
               end else if (is_save) begin
                  nxt_branch = 1'b1;
                  nxt_target = tgt;
                  nxt_pex_we = 1'b1;
                  nxt_pey_we = dual_element_mode_i;
                  nxt_save = frame_pointer_i;
                  nxt_fp_we = 1'b1;
                  nxt_fp = stack_pointer_i;
               end else if (is_restore) begin
                  nxt_sp_we = 1'b1;
                  nxt_sp = frame_pointer_i;
                  nxt_mem_rd = 1'b1;
                  nxt_mem_addr = frame_pointer_i + 32'(mcd_pkg::RESTORE_OFS0);
                  nxt_loads = dual_element_mode_i ? 2'h2 : 2'h1;
               end else if (!is_nop) begin
                  // any other word is treated as carrying a compute field
                  nxt_cv = 1'b1;
                  nxt_cu = dec_unit;
                  nxt_cop = dec_op;
                  nxt_crn = dec_rn;
                  nxt_crx = dec_rx;
                  nxt_cry = dec_ry;
                  nxt_crs = dec_rs;
               end
            end else if (mem_rvalid_i && loads_ff != 2'h0) begin
               nxt_fp_we = 1'b1;
               nxt_fp = mem_rdata_i;
               nxt_loads = loads_ff - 2'h1;
               if (loads_ff == 2'h2) begin
                  // second load addressed from the old frame pointer
                  nxt_mem_rd = 1'b1;
                  nxt_mem_addr = sp_ff + 32'(mcd_pkg::RESTORE_OFS1);
               end
            end
         end
         mcd_pkg::MCD_WAIT: begin
            if (irq_i) begin
               nxt_state = mcd_pkg::MCD_RUN;
            end
         end
         default: nxt_state = mcd_pkg::MCD_RUN;
      endcase
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_ff <= mcd_pkg::MCD_RUN;
         resume_ff <= '0;
         branch_ff <= 1'b0;
         target_ff <= '0;
         pex_we_ff <= 1'b0;
         pey_we_ff <= 1'b0;
         save_ff <= 32'h0;
         sp_we_ff <= 1'b0;
         sp_ff <= 32'h0;
         fp_we_ff <= 1'b0;
         fp_ff <= 32'h0;
         mem_rd_ff <= 1'b0;
         mem_addr_ff <= 32'h0;
         loads_ff <= 2'h0;
         adv_ff <= 1'b0;
         cv_ff <= 1'b0;
         cu_ff <= mcd_pkg::MCD_UNIT_NONE;
         cop_ff <= 8'h0;
         crn_ff <= 4'h0;
         crx_ff <= 4'h0;
         cry_ff <= 4'h0;
         crs_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         resume_ff <= nxt_resume;
         branch_ff <= nxt_branch;
         target_ff <= nxt_target;
         pex_we_ff <= nxt_pex_we;
         pey_we_ff <= nxt_pey_we;
         save_ff <= nxt_save;
         sp_we_ff <= nxt_sp_we;
         sp_ff <= nxt_sp;
         fp_we_ff <= nxt_fp_we;
         fp_ff <= nxt_fp;
         mem_rd_ff <= nxt_mem_rd;
         mem_addr_ff <= nxt_mem_addr;
         loads_ff <= nxt_loads;
         adv_ff <= nxt_adv;
         cv_ff <= nxt_cv;
         cu_ff <= nxt_cu;
         cop_ff <= nxt_cop;
         crn_ff <= nxt_crn;
         crx_ff <= nxt_crx;
         cry_ff <= nxt_cry;
         crs_ff <= nxt_crs;
      end
   end

   assign fetch_advance_o = adv_ff;
   assign low_power_o = state_ff == mcd_pkg::MCD_WAIT;
   assign resume_addr_o = resume_ff;
   assign branch_o = branch_ff;
   assign branch_target_o = target_ff;
   assign pex_save_we_o = pex_we_ff;
   assign pey_save_we_o = pey_we_ff;
   assign save_data_o = save_ff;
   assign sp_we_o = sp_we_ff;
   assign sp_data_o = sp_ff;
   assign fp_we_o = fp_we_ff;
   assign fp_data_o = fp_ff;
   assign mem_rd_o = mem_rd_ff;
   assign mem_addr_o = mem_addr_ff;
   assign cmp_valid_o = cv_ff;
   assign cmp_unit_o = cu_ff;
   assign cmp_op_o = cop_ff;
   assign cmp_rn_o = crn_ff;
   assign cmp_rx_o = crx_ff;
   assign cmp_ry_o = cry_ff;
   assign cmp_rn_src_o = crs_ff;
endmodule

// ### mcd_dm_model.sv
`timescale 1ns/1ps
module mcd_dm_model (
   input wire logic clock_i, // core clock
   input wire logic arst_n_i, // async reset
   input wire logic mem_rd_i, // read strobe
   input wire logic [31:0] mem_addr_i, // read address
   input wire logic [3:0] lat_i, // extra wait cycles
   output logic [31:0] rdata_o, // read data
   output logic rvalid_o // read returned
);
   logic busy_ff;
   logic [3:0] cnt_ff;
   logic [31:0] adr_ff;
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_ff <= 1'b0;
         cnt_ff <= 4'h0;
         adr_ff <= 32'h0;
         rvalid_o <= 1'b0;
         rdata_o <= 32'h0;
      end else begin
         rvalid_o <= 1'b0;
         // data toggles when not valid so a stale read cannot pass
         rdata_o <= ~rdata_o;
         if (mem_rd_i) begin
            busy_ff <= 1'b1;
            cnt_ff <= lat_i;
            adr_ff <= mem_addr_i;
         end else if (busy_ff && cnt_ff == 4'h0) begin
            busy_ff <= 1'b0;
            rvalid_o <= 1'b1;
            rdata_o <= adr_ff ^ 32'h5A5A_0000;
         end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 4'h1;
         end
      end
   end
endmodule

// ### mcd_misc_decode_chk.sv
`timescale 1ns/1ps
module mcd_misc_decode_chk #(
   parameter int ADDR_W = 24
) (
   input wire logic clock_i, // clock
   input wire logic arst_n_i, // reset
   input wire logic instr_valid_i, // word present
   input wire logic [47:0] instr_i, // word
   input wire logic [ADDR_W-1:0] pc_i, // pc
   input wire logic dual_element_mode_i, // mode
   input wire logic irq_i, // interrupt
   input wire logic [31:0] frame_pointer_i, // fp
   input wire logic [31:0] stack_pointer_i, // sp
   input wire logic [31:0] mem_rdata_i, // read data
   input wire logic mem_rvalid_i, // read back
   input wire logic instr_ready_o, // ready
   input wire logic fetch_advance_o, // advance
   input wire logic low_power_o, // asleep
   input wire logic [ADDR_W-1:0] resume_addr_o, // resume
   input wire logic branch_o, // branch
   input wire logic [ADDR_W-1:0] branch_target_o, // target
   input wire logic pex_save_we_o, // x save
   input wire logic pey_save_we_o, // y save
   input wire logic [31:0] save_data_o, // save data
   input wire logic sp_we_o, // sp write
   input wire logic [31:0] sp_data_o, // sp data
   input wire logic fp_we_o, // fp write
   input wire logic [31:0] fp_data_o, // fp data
   input wire logic mem_rd_o, // read
   input wire logic [31:0] mem_addr_o, // read address
   input wire logic cmp_valid_o // compute
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   logic [7:0] hi;
   logic [ADDR_W-1:0] fld;
   logic [ADDR_W-1:0] rel_sum;
   assign hi = instr_i[47:40];
   assign fld = instr_i[ADDR_W-1:0];
   assign rel_sum = pc_i + fld;
   wire logic take = instr_valid_i && instr_ready_o;
   wire logic nop_w = take && hi == 8'h00 && !instr_i[39];
   wire logic idle_w = take && hi == 8'h00 && instr_i[39];
   wire logic sav_w = take && hi == 8'h18 && instr_i[35:32] == 4'h4
      && (instr_i[39:36] == 4'h0 || instr_i[39:36] == 4'h4);
   wire logic rst_w = take && hi == 8'h19;
   sequence s_quiet;
      !branch_o && !sp_we_o && !fp_we_o && !mem_rd_o && !cmp_valid_o && !pex_save_we_o;
   endsequence
   sequence s_asleep;
      low_power_o && fetch_advance_o && !instr_ready_o;
   endsequence
   a_nop_quiet: assert property (nop_w |=> fetch_advance_o ##0 s_quiet ##0 !low_power_o)
      else $error("nop changed state");
   a_idle_enter: assert property (idle_w |=> s_quiet ##0 s_asleep)
      else $error("wait did not sleep");
   a_idle_hold: assert property (low_power_o && !irq_i |=> low_power_o)
      else $error("sleep ended without interrupt");
   a_idle_wake: assert property (low_power_o && irq_i |=> !low_power_o && instr_ready_o)
      else $error("interrupt did not wake");
   a_resume_addr: assert property (idle_w |=> resume_addr_o == $past(pc_i) + 1'b1)
      else $error("resume address wrong");
   a_save_xfer: assert property (sav_w |=> branch_o && pex_save_we_o && fp_we_o
      && save_data_o == $past(frame_pointer_i) && fp_data_o == $past(stack_pointer_i)
      && pey_save_we_o == $past(dual_element_mode_i))
      else $error("frame save transfers wrong");
   a_dir_target: assert property (sav_w && !instr_i[38] |=> branch_target_o == $past(fld))
      else $error("direct target wrong");
   a_rel_target: assert property (sav_w && instr_i[38]
      |=> branch_target_o == $past(rel_sum))
      else $error("relative target wrong");
   a_restore_go: assert property (rst_w |=> sp_we_o && mem_rd_o && !instr_ready_o
      && sp_data_o == $past(frame_pointer_i) && mem_addr_o == $past(frame_pointer_i))
      else $error("restore start wrong");
   a_fp_reload: assert property (mem_rvalid_i
      |=> fp_we_o && fp_data_o == $past(mem_rdata_i))
      else $error("frame pointer load wrong");
endmodule
bind mcd_misc_decode mcd_misc_decode_chk #(.ADDR_W(ADDR_W)) u_chk (.clock_i(clock_i),
   .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i),
   .dual_element_mode_i(dual_element_mode_i), .irq_i(irq_i), .frame_pointer_i(frame_pointer_i),
   .stack_pointer_i(stack_pointer_i), .mem_rdata_i(mem_rdata_i), .mem_rvalid_i(mem_rvalid_i),
   .instr_ready_o(instr_ready_o), .fetch_advance_o(fetch_advance_o), .low_power_o(low_power_o),
   .resume_addr_o(resume_addr_o), .branch_o(branch_o), .branch_target_o(branch_target_o),
   .pex_save_we_o(pex_save_we_o), .pey_save_we_o(pey_save_we_o), .save_data_o(save_data_o),
   .sp_we_o(sp_we_o), .sp_data_o(sp_data_o), .fp_we_o(fp_we_o), .fp_data_o(fp_data_o),
   .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .cmp_valid_o(cmp_valid_o));

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic instr_valid_i = 1'b0;
   logic [47:0] instr_i = 48'h0;
   logic [23:0] pc_i = 24'h0;
   logic dual_element_mode_i = 1'b0;
   logic irq_i = 1'b0;
   logic [31:0] frame_pointer_i = 32'h0000_1000;
   logic [31:0] stack_pointer_i = 32'h0000_2000;
   logic [31:0] mem_rdata_i;
   logic mem_rvalid_i;
   logic [3:0] lat = 4'h0;
   logic instr_ready_o, fetch_advance_o, low_power_o, branch_o, pex_save_we_o, pey_save_we_o;
   logic sp_we_o, fp_we_o, mem_rd_o, cmp_valid_o, cmp_rn_src_o;
   logic [23:0] resume_addr_o, branch_target_o;
   logic [31:0] save_data_o, sp_data_o, fp_data_o, mem_addr_o;
   mcd_pkg::mcd_unit_t cmp_unit_o;
   logic [7:0] cmp_op_o;
   logic [3:0] cmp_rn_o, cmp_rx_o, cmp_ry_o;
   int fails = 0;
   int n_checks = 0;
   int cycles = 0;
   mcd_misc_decode DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .pc_i(pc_i), .dual_element_mode_i(dual_element_mode_i), .irq_i(irq_i),
      .frame_pointer_i(frame_pointer_i), .stack_pointer_i(stack_pointer_i),
      .mem_rdata_i(mem_rdata_i), .mem_rvalid_i(mem_rvalid_i), .instr_ready_o(instr_ready_o),
      .fetch_advance_o(fetch_advance_o), .low_power_o(low_power_o),
      .resume_addr_o(resume_addr_o), .branch_o(branch_o), .branch_target_o(branch_target_o),
      .pex_save_we_o(pex_save_we_o), .pey_save_we_o(pey_save_we_o), .save_data_o(save_data_o),
      .sp_we_o(sp_we_o), .sp_data_o(sp_data_o), .fp_we_o(fp_we_o), .fp_data_o(fp_data_o),
      .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .cmp_valid_o(cmp_valid_o),
      .cmp_unit_o(cmp_unit_o), .cmp_op_o(cmp_op_o), .cmp_rn_o(cmp_rn_o), .cmp_rx_o(cmp_rx_o),
      .cmp_ry_o(cmp_ry_o), .cmp_rn_src_o(cmp_rn_src_o));
   mcd_dm_model u_dm (.clock_i(clock_i), .arst_n_i(arst_n_i), .mem_rd_i(mem_rd_o),
      .mem_addr_i(mem_addr_o), .lat_i(lat), .rdata_o(mem_rdata_i), .rvalid_o(mem_rvalid_i));
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // called at a falling edge; effects are readable when it returns
   task automatic send(input logic [47:0] w, input logic [23:0] pc);
      // one idle edge so valid is never dropped and raised at one instant
      @(negedge clock_i);
      for (int i = 0; i < 50 && instr_ready_o !== 1'b1; i++) @(negedge clock_i);
      instr_i = w;
      pc_i = pc;
      instr_valid_i = 1'b1;
      @(negedge clock_i);
      instr_valid_i = 1'b0;
   endtask
   task automatic t_nop();
      for (int m = 0; m < 2; m++) begin
         dual_element_mode_i = m[0];
         send(48'h0, 24'h000010);
         chk("advance", 1, fetch_advance_o);
         chk("effects", 0, {branch_o, pex_save_we_o, pey_save_we_o, sp_we_o, fp_we_o,
            mem_rd_o, cmp_valid_o, low_power_o});
      end
   endtask
   task automatic t_idle();
      send(48'h0080_0000_0000, 24'hFFFFFF);
      chk("sleep", 1, low_power_o);
      chk("advance", 1, fetch_advance_o);
      chk("resume", 24'h000000, resume_addr_o);
      repeat (6) @(negedge clock_i);
      chk("still asleep", 1, low_power_o);
      chk("refused", 0, instr_ready_o);
      irq_i = 1'b1;
      @(negedge clock_i);
      irq_i = 1'b0;
      chk("woken", 0, low_power_o);
   endtask
   task automatic t_save(input logic d, input logic r, input logic [23:0] f);
      logic [23:0] t;
      t = r ? 24'h000100 + f : f;
      dual_element_mode_i = d;
      send({8'h18, 1'b0, r, 2'b00, 4'h4, 8'h00, f}, 24'h000100);
      chk("branch", 1, branch_o);
      chk("target", t, branch_target_o);
      chk("saves", {d, 1'b1, 1'b1}, {pey_save_we_o, pex_save_we_o, fp_we_o});
      chk("save data", frame_pointer_i, save_data_o);
      chk("fp from sp", stack_pointer_i, fp_data_o);
   endtask
   task automatic t_restore(input logic d, input logic [3:0] l);
      logic [31:0] fp;
      fp = frame_pointer_i;
      lat = l;
      dual_element_mode_i = d;
      send(48'h1900_0000_0000, 24'h000200);
      chk("sp from fp", fp, sp_data_o);
      chk("read at", fp, mem_addr_o);
      chk("strobes", 2'b11, {sp_we_o, mem_rd_o});
      chk("held off", 0, instr_ready_o);
      for (int i = 0; i < 20 && fp_we_o !== 1'b1; i++) @(negedge clock_i);
      chk("fp load", fp ^ 32'h5A5A_0000, fp_data_o);
      if (d) begin
         for (int i = 0; i < 20 && mem_rd_o !== 1'b1; i++) @(negedge clock_i);
         chk("second read at", fp + 32'h1, mem_addr_o);
         @(negedge clock_i);
         for (int i = 0; i < 20 && fp_we_o !== 1'b1; i++) @(negedge clock_i);
         chk("second load", (fp + 32'h1) ^ 32'h5A5A_0000, fp_data_o);
      end
   endtask
   task automatic t_cmp(input logic [22:0] cf, input logic [2:0] u, input logic src);
      send({8'h0F, 17'h1ABCD, cf}, 24'h000300);
      chk("valid", 1, cmp_valid_o);
      chk("unit", u, cmp_unit_o);
      // opcode and register layout is only checked for ALU, multiplier and shifter forms
      if (!cf[22] && cf[21:20] != 2'b11) begin
         chk("opcode", cf[19:12], cmp_op_o);
         chk("regs", cf[11:0], {cmp_rn_o, cmp_rx_o, cmp_ry_o});
         chk("third source", src, cmp_rn_src_o);
      end
   endtask
   initial begin
      repeat (2) @(negedge clock_i);
      arst_n_i = 1'b1;
      chk("ready after reset", 1, instr_ready_o);
      chk("asleep after reset", 0, low_power_o);
      t_nop();
      t_idle();
      t_save(1'b0, 1'b0, 24'hABCDEF);
      t_save(1'b1, 1'b1, 24'hFFFFF0);
      t_save(1'b0, 1'b1, 24'h000020);
      t_save(1'b1, 1'b0, 24'h000001);
      t_restore(1'b0, 4'h0);
      t_restore(1'b1, 4'h5);
      t_cmp(23'h001A53, mcd_pkg::MCD_UNIT_ALU, 1'b0);
      t_cmp(23'h140321, mcd_pkg::MCD_UNIT_MUL, 1'b0);
      t_cmp(23'h280F0F, mcd_pkg::MCD_UNIT_SHF, 1'b1);
      t_cmp(23'h2015A5, mcd_pkg::MCD_UNIT_SHF, 1'b0);
      t_cmp(23'h300123, mcd_pkg::MCD_UNIT_ACC, 1'b0);
      t_cmp(23'h4C3210, mcd_pkg::MCD_UNIT_MULTI, 1'b0);
      // reset while a restore load is still outstanding
      lat = 4'h9;
      send(48'h1900_0000_0000, 24'h000400);
      arst_n_i = 1'b0;
      @(negedge clock_i);
      arst_n_i = 1'b1;
      chk("ready after second reset", 1, instr_ready_o);
      chk("no load after reset", 0, fp_we_o);
      send(48'h0, 24'h000500);
      chk("taken after reset", 1, fetch_advance_o);
      tally_and_finish();
   end
endmodule
